// >>> common/srb_pkg.sv
package srb_pkg;
   // Word indices of the bank 3 registers; the bus byte address is four times the index.
   localparam logic [8:0] IDX_INDIRECT = 9'h180;
   localparam logic [8:0] IDX_OPTION = 9'h181;
   localparam logic [8:0] IDX_PCL = 9'h182;
   localparam logic [8:0] IDX_FLAGS = 9'h183;
   localparam logic [8:0] IDX_POINTER = 9'h184;
   localparam logic [8:0] IDX_TRIS_B = 9'h186;
   localparam logic [8:0] IDX_TRIS_F = 9'h187;
   localparam logic [8:0] IDX_TRIS_G = 9'h188;
   localparam logic [8:0] IDX_PROGRAM_COUNTER_HIGH_LATCH = 9'h18a;
   localparam logic [8:0] IDX_INTCTL = 9'h18b;
   // Core-side control word: ALU flag update and status strobes.
   localparam logic [8:0] IDX_CORE_CTL = 9'h1a0;
   // Converter and port A words of the analog variant.
   localparam logic [8:0] IDX_CONV_RESULT = 9'h1a1;
   localparam logic [8:0] IDX_CONV_CTL0 = 9'h1a2;
   localparam logic [8:0] IDX_CONV_CTL1 = 9'h1a3;
   localparam logic [8:0] IDX_PORT_A = 9'h1a4;
   // Status bit positions.
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_PD = 3;
   localparam int FLAG_TO = 4;
   // Core control word fields.
   localparam int CTL_ALU_UPD = 0;
   localparam int CTL_SUB = 1;
   localparam int CTL_SLEEP = 2;
   localparam int CTL_WDT = 3;
   localparam int CTL_CLRWDT = 4;
   // Reset values and bit masks.
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] RST_TRIS = 8'hff;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_FLAGS = 8'h18;
   localparam logic [7:0] MASK_PROGRAM_COUNTER_HIGH_LATCH = 8'h1f;
   localparam logic [7:0] MASK_PORT_A = 8'h3f;
   localparam logic [7:0] MASK_PORT_A_DIGITAL = 8'h10;
   localparam logic [7:0] MASK_CONV_CTL0 = 8'hfd;
   // Size of the display-style general storage behind the indirect port.
   localparam int DATA_DEPTH = 256;
endpackage : srb_pkg

// >>> verilog/srb_alu_flags.sv
// Computes the zero, digit carry and carry flags of an ALU add or subtract.
module srb_alu_flags (
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic sub_i,
   output logic [7:0] result_o,
   output logic z_o,
   output logic dc_o,
   output logic c_o
);
   logic [8:0] full; // Nine-bit sum carrying the carry out.
   logic [4:0] nib; // Low nibble sum carrying the digit carry.

   // Subtraction adds the two's complement, so carries come out as inverted borrows.
   always_comb begin
      if (sub_i) begin
         full = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
         nib = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
      end else begin
         full = {1'b0, a_i} + {1'b0, b_i};
         nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
      end
      result_o = full[7:0];
      z_o = (full[7:0] == 8'h00);
      dc_o = nib[4];
      c_o = full[8];
   end
endmodule : srb_alu_flags

// >>> verilog/srb_data_store.sv
// Flip-flop storage reached through the indirect pointer; all bits behave as plain RAM.
module srb_data_store #(
   parameter int DEPTH = srb_pkg::DATA_DEPTH
) (
   input wire logic sys_clk_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [DEPTH]; // Storage words, left uninitialised like the pixel RAM.

   // Write port; locations without a pixel still keep their value.
   always_ff @(posedge sys_clk_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Asynchronous read so the APB answer is ready in the access phase.
   assign rdata_o = mem[addr_i];
endmodule : srb_data_store

// >>> verilog/srb_bank3.sv
// Operation
// - Any access may target the status register.
// - Status holds flags, reset cause, bank bits.
// - ALU flag update overrides written flag bits.
// - Timeout and power-down bits ignore writes.
// - Subtract carries are inverted borrows.
// - Unimplemented words and bits read zero.
// - No converter variant hides converter registers.
// - Non-pixel display bits act as RAM.
// - Port A reset and read per variant.
//
// Local design decision: register access over APB.
module srb_bank3 #(
   parameter bit HAS_CONVERTER = 1'b1
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic por_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [7:0] alu_operand_i,
   input wire logic [7:0] converter_result_i,
   input wire logic [5:0] port_a_pins_i,
   output logic [7:0] option_o,
   output logic [7:0] status_o,
   output logic [7:0] tris_b_o,
   output logic [7:0] tris_f_o,
   output logic [7:0] tris_g_o,
   output logic [12:0] pc_o
);
   // Registers that software reaches over the bus.
   logic [7:0] option_reg; // Timer and pull-up configuration.
   logic [7:0] pcl_reg; // Program counter low byte.
   logic [7:0] status_reg; // Flags, reset cause and bank selects.
   logic [7:0] pointer_reg; // Indirect pointer.
   logic [7:0] tris_b_reg; // Port B direction, one bit per pin.
   logic [7:0] tris_f_reg; // Port F direction, one bit per pin.
   logic [7:0] tris_g_reg; // Port G direction, one bit per pin.
   logic [7:0] program_counter_high_latch_reg; // Upper program counter buffer, five bits.
   logic [7:0] intctl_reg; // Interrupt enables and flags.
   // Converter variant registers; the two control words stay at zero in the bare variant.
   logic [7:0] conv_ctl0_reg; // First converter control word.
   logic [7:0] conv_ctl1_reg; // Second converter control word.
   logic [7:0] port_a_reg; // Port A output latch.
   // Core-side state that the bus does not see as a plain register.
   logic [7:0] core_ctl_reg; // Core-side flag update and subtract modes.
   logic [4:0] pc_high_reg; // Upper program counter bits loaded on PROGRAM_COUNTER_LOW write.
   // Bus decode.
   logic [8:0] idx; // Word index from the byte address.
   logic wr_en; // Write takes effect this edge.
   logic [7:0] wbyte; // Low data byte written.
   // Results of the two submodules.
   logic [7:0] store_rdata; // Byte at the pointer in the storage.
   logic alu_z; // Zero flag of the ALU.
   logic alu_dc; // Digit carry out of the low nibble.
   logic alu_c; // Carry out of bit seven.
   // Read path and status next value.
   logic [7:0] rd_byte; // Read data before widening.
   logic [7:0] status_next; // Status value for the next edge.

   // Decodes a word index into a target flag.
   function automatic logic hit(input logic [8:0] a, input logic [8:0] b);
      return a == b;
   endfunction : hit

   // The word index drops the two byte-lane bits of the address.
   assign idx = paddr_i[10:2];
   // A write lands at the access edge, and only with the low byte lane enabled.
   assign wr_en = psel_i && penable_i && pwrite_i && pstrb_i[0];
   // Every register is one byte wide, so only the low lane carries data.
   assign wbyte = pwdata_i[7:0];
   // Zero-wait slave: every access completes in its first access cycle.
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;

   // Indirect storage addressed by the pointer.
   srb_data_store u_store (
      .sys_clk_i(sys_clk_i),
      .addr_i(pointer_reg),
      .wr_i(wr_en && hit(idx, srb_pkg::IDX_INDIRECT)),
      .wdata_i(wbyte),
      .rdata_o(store_rdata)
   );

   // The ALU combines written data with the core operand.
   // The sum itself is not stored; only its flags feed the status register.
   srb_alu_flags u_alu (
      .a_i(wbyte),
      .b_i(alu_operand_i),
      .sub_i(core_ctl_reg[srb_pkg::CTL_SUB]),
      .result_o(),
      .z_o(alu_z),
      .dc_o(alu_dc),
      .c_o(alu_c)
   );

   // Next status value: write, then flag override, then reset-cause events.
   always_comb begin
      status_next = status_reg;
      if (wr_en && hit(idx, srb_pkg::IDX_FLAGS)) begin
         // Bank bits and flags take the data; reset-cause bits are kept.
         status_next[7:5] = wbyte[7:5];
         status_next[2:0] = wbyte[2:0];
         if (core_ctl_reg[srb_pkg::CTL_ALU_UPD]) begin
            // Flag-affecting instruction: the data write to flags is blocked.
            status_next[srb_pkg::FLAG_Z] = alu_z;
            status_next[srb_pkg::FLAG_DC] = alu_dc;
            status_next[srb_pkg::FLAG_C] = alu_c;
         end
      end
      // Only sleep and watchdog logic touch the reset-cause bits.
      if (wr_en && hit(idx, srb_pkg::IDX_CORE_CTL)) begin
         if (wbyte[srb_pkg::CTL_SLEEP]) begin
            status_next[srb_pkg::FLAG_PD] = 1'b0;
            status_next[srb_pkg::FLAG_TO] = 1'b1;
         end
         if (wbyte[srb_pkg::CTL_CLRWDT]) begin
            status_next[srb_pkg::FLAG_PD] = 1'b1;
            status_next[srb_pkg::FLAG_TO] = 1'b1;
         end
         if (wbyte[srb_pkg::CTL_WDT]) begin
            status_next[srb_pkg::FLAG_TO] = 1'b0;
         end
      end
   end

   // Status register; power-on sets both cause bits, other resets keep them.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         // Every reset clears the bank selects.
         status_reg[7:5] <= 3'h0;
         // Power-on also loads the cause bits and clears the flags.
         if (por_i) begin
            status_reg <= srb_pkg::RST_FLAGS;
         end
      end else begin
         status_reg <= status_next;
      end
   end

   // Core control word, written by the instruction datapath.
   // Only the update and subtract modes are kept; the status strobes act in their write cycle.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         core_ctl_reg <= srb_pkg::RST_ZERO;
      end else if (wr_en && hit(idx, srb_pkg::IDX_CORE_CTL)) begin
         core_ctl_reg <= wbyte & 8'h03; // Strobe bits are not stored.
      end
   end

   // Timer and pull-up configuration; resets to all ones.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         option_reg <= srb_pkg::RST_OPTION;
      end else if (wr_en && hit(idx, srb_pkg::IDX_OPTION)) begin
         option_reg <= wbyte;
      end
   end

   // Port B direction; all pins start as inputs.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tris_b_reg <= srb_pkg::RST_TRIS;
      end else if (wr_en && hit(idx, srb_pkg::IDX_TRIS_B)) begin
         tris_b_reg <= wbyte;
      end
   end

   // Port F direction; all pins start as inputs.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tris_f_reg <= srb_pkg::RST_TRIS;
      end else if (wr_en && hit(idx, srb_pkg::IDX_TRIS_F)) begin
         tris_f_reg <= wbyte;
      end
   end

   // Port G direction; all pins start as inputs.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         tris_g_reg <= srb_pkg::RST_TRIS;
      end else if (wr_en && hit(idx, srb_pkg::IDX_TRIS_G)) begin
         tris_g_reg <= wbyte;
      end
   end

   // Interrupt control; enables and flags start cleared.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         intctl_reg <= srb_pkg::RST_ZERO;
      end else if (wr_en && hit(idx, srb_pkg::IDX_INTCTL)) begin
         intctl_reg <= wbyte;
      end
   end

   // Indirect pointer; its reset value is unknown, kept as-is on reset.
   // Storage reached through it therefore needs a pointer write before first use.
   always_ff @(posedge sys_clk_i) begin
      if (wr_en && hit(idx, srb_pkg::IDX_POINTER)) begin
         pointer_reg <= wbyte;
      end
   end

   // Upper program counter buffer; only its low five bits exist.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         program_counter_high_latch_reg <= srb_pkg::RST_ZERO;
      end else if (wr_en && hit(idx, srb_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH)) begin
         program_counter_high_latch_reg <= wbyte & srb_pkg::MASK_PROGRAM_COUNTER_HIGH_LATCH;
      end
   end

   // Program counter low byte; writing it loads the buffered high bits as well.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pcl_reg <= srb_pkg::RST_ZERO;
         pc_high_reg <= 5'h00;
      end else if (wr_en && hit(idx, srb_pkg::IDX_PCL)) begin
         pcl_reg <= wbyte;
         pc_high_reg <= program_counter_high_latch_reg[4:0];
      end
   end

   // First converter control word; absent in the bare variant, and its reserved bit never stores.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !HAS_CONVERTER) begin
         conv_ctl0_reg <= srb_pkg::RST_ZERO;
      end else if (wr_en && hit(idx, srb_pkg::IDX_CONV_CTL0)) begin
         conv_ctl0_reg <= wbyte & srb_pkg::MASK_CONV_CTL0;
      end
   end

   // Second converter control word; absent in the bare variant.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i || !HAS_CONVERTER) begin
         conv_ctl1_reg <= srb_pkg::RST_ZERO;
      end else if (wr_en && hit(idx, srb_pkg::IDX_CONV_CTL1)) begin
         conv_ctl1_reg <= wbyte;
      end
   end

   // Port A latch: the converter variant clears it on reset, the other keeps it.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         if (HAS_CONVERTER) begin
            port_a_reg <= srb_pkg::RST_ZERO;
         end
      end else if (wr_en && hit(idx, srb_pkg::IDX_PORT_A)) begin
         port_a_reg <= wbyte & srb_pkg::MASK_PORT_A;
      end
   end

   // Read multiplexer; unmapped words read as zero.
   // The case covers every implemented index; anything else falls to the default.
   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         srb_pkg::IDX_INDIRECT: rd_byte = store_rdata;
         srb_pkg::IDX_OPTION: rd_byte = option_reg;
         srb_pkg::IDX_PCL: rd_byte = pcl_reg;
         srb_pkg::IDX_FLAGS: rd_byte = status_reg;
         srb_pkg::IDX_POINTER: rd_byte = pointer_reg;
         srb_pkg::IDX_TRIS_B: rd_byte = tris_b_reg;
         srb_pkg::IDX_TRIS_F: rd_byte = tris_f_reg;
         srb_pkg::IDX_TRIS_G: rd_byte = tris_g_reg;
         srb_pkg::IDX_PROGRAM_COUNTER_HIGH_LATCH: rd_byte = program_counter_high_latch_reg & srb_pkg::MASK_PROGRAM_COUNTER_HIGH_LATCH;
         srb_pkg::IDX_INTCTL: rd_byte = intctl_reg;
         srb_pkg::IDX_CORE_CTL: rd_byte = core_ctl_reg;
         srb_pkg::IDX_CONV_RESULT: rd_byte = HAS_CONVERTER ? converter_result_i : 8'h00;
         srb_pkg::IDX_CONV_CTL0: rd_byte = conv_ctl0_reg;
         srb_pkg::IDX_CONV_CTL1: rd_byte = conv_ctl1_reg;
         // The converter variant reads only its one digital pin; the analog pins read zero.
         srb_pkg::IDX_PORT_A: rd_byte = HAS_CONVERTER ? ({2'b00, port_a_pins_i} & srb_pkg::MASK_PORT_A_DIGITAL)
            : {2'b00, port_a_pins_i};
         default: rd_byte = 8'h00;
      endcase
   end

   // Read data register, loaded in the setup cycle of a read so it is settled for the access phase.
   // Writes and idle cycles leave it alone; it holds the last byte read.
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= {24'h00_0000, rd_byte};
      end
   end

   // Outputs towards the rest of the core.
   // They come straight from the registers, so they never glitch.
   // The program counter joins the buffered high bits to the low byte.
   assign option_o = option_reg;
   assign status_o = status_reg;
   assign tris_b_o = tris_b_reg;
   assign tris_f_o = tris_f_reg;
   assign tris_g_o = tris_g_reg;
   assign pc_o = {pc_high_reg, pcl_reg};
endmodule : srb_bank3

// >>> verif/srb_bank3_assertions.sv
// Watches the bank 3 ports: bus answer, status cause bits, reset values and read-as-zero places.
module srb_bank3_checker (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic por_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [7:0] option_o,
   input wire logic [7:0] status_o,
   input wire logic [7:0] tris_b_o,
   input wire logic [12:0] pc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // A write that lands at this edge.
   logic wr;
   assign wr = psel_i && penable_i && pwrite_i && pstrb_i[0];
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   bus_answer_ok_a: assert property (pready_o && !pslverr_o) else $error("bus answer late or errored");
   upper_bits_zero_a: assert property (prdata_o[31:8] == 24'h0) else $error("read data upper bits set");
   cause_bits_hold_a: assert property (!(wr && paddr_i == 12'h680) |=> $stable(status_o[4:3]))
      else $error("cause bits changed by a plain write");
   bank_bits_write_a: assert property (wr && paddr_i == 12'h60c |=> status_o[7:5] == $past(pwdata_i[7:5]))
      else $error("bank bits not written");
   option_write_a: assert property (wr && paddr_i == 12'h604 |=> option_o == $past(pwdata_i[7:0]))
      else $error("option byte not written");
   strobe_gate_a: assert property (psel_i && penable_i && pwrite_i && !pstrb_i[0] |=> $stable(tris_b_o))
      else $error("write without byte strobe landed");
   hole_reads_zero_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == 12'h614 |=> prdata_o == 32'h0)
      else $error("unmapped word read nonzero");
   reset_values_a: assert property ($rose(rst_n_i) |-> option_o == 8'hff && tris_b_o == 8'hff
      && pc_o[7:0] == 8'h0 && status_o[7:5] == 3'b000) else $error("reset values wrong");
   power_on_cause_a: assert property ($rose(rst_n_i) && $past(por_i) |-> status_o[4:3] == 2'b11)
      else $error("power-on cause bits wrong");
   sleep_cause_a: assert property (wr && paddr_i == 12'h680 && pwdata_i[2] |=> status_o[4:3] == 2'b10)
      else $error("sleep cause bits wrong");
endmodule : srb_bank3_checker

bind srb_bank3 srb_bank3_checker u_chk (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .por_i(por_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .option_o(option_o), .status_o(status_o),
   .tris_b_o(tris_b_o), .pc_o(pc_o));

// >>> verif/test_special_register_bank_three_status.sv
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: %h", $time, a); end end
// Drives the bank over APB; a second copy without the converter shares the bus.
module test_special_register_bank_three_status;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, por = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, prdata2, rd, rd2;
   logic [3:0] pstrb = 4'h0;
   logic [7:0] opnd = 8'h0, conv = 8'h3c, option, status, port_b_direction, port_f_direction, port_g_direction;
   logic [5:0] pins = 6'h3a;
   logic [12:0] pc;
   logic pready, pslverr;
   int failures = 0, checked = 0;
   srb_bank3 #(.HAS_CONVERTER(1'b1)) DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .por_i(por), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .alu_operand_i(opnd), .converter_result_i(conv),
      .port_a_pins_i(pins), .option_o(option), .status_o(status), .tris_b_o(port_b_direction), .tris_f_o(port_f_direction),
      .tris_g_o(port_g_direction), .pc_o(pc));
   srb_bank3 #(.HAS_CONVERTER(1'b0)) DUT_BARE (.sys_clk_i(clk), .rst_n_i(rst_n), .por_i(por), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata2),
      .pready_o(), .pslverr_o(), .alu_operand_i(opnd), .converter_result_i(conv), .port_a_pins_i(pins),
      .option_o(), .status_o(), .tris_b_o(), .tris_f_o(), .tris_g_o(), .pc_o());
   always #12.5 clk = ~clk;
   // One APB transfer: setup, then access until pready is sampled high.
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      paddr <= a;
      pwr <= w;
      pwdata <= {24'h0, d};
      pstrb <= s;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      rd2 = prdata2;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(a, 1'b1, d, 4'h1);
   endtask : wr
   task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
      apb(a, 1'b0, 8'h0, 4'h0);
      `CHK(rd, {24'h0, e})
   endtask : chk_rd
   task t_reset;
      chk_rd(12'h604, 8'hff);
      chk_rd(12'h618, 8'hff);
      chk_rd(12'h61c, 8'hff);
      chk_rd(12'h620, 8'hff);
      chk_rd(12'h608, 8'h00);
      chk_rd(12'h628, 8'h00);
      chk_rd(12'h62c, 8'h00);
      chk_rd(12'h60c, 8'h18);
      `CHK({port_b_direction, port_f_direction, port_g_direction}, 24'hffffff)
      $display("reset test done");
   endtask : t_reset
   // Plain writes keep the cause bits; ALU updates replace the written flags.
   task t_status;
      wr(12'h680, 8'h00);
      wr(12'h60c, 8'hff);
      chk_rd(12'h60c, 8'hff);
      wr(12'h60c, 8'h00);
      chk_rd(12'h60c, 8'h18);
      opnd <= 8'h01;
      wr(12'h680, 8'h01);
      wr(12'h60c, 8'haf);
      chk_rd(12'h60c, 8'hba);
      wr(12'h680, 8'h03);
      wr(12'h60c, 8'h10);
      chk_rd(12'h60c, 8'h19);
      opnd <= 8'h05;
      wr(12'h60c, 8'h05);
      chk_rd(12'h60c, 8'h1f);
      wr(12'h680, 8'h00);
      $display("status test done");
   endtask : t_status
   task t_indirect;
      wr(12'h610, 8'h25);
      wr(12'h600, 8'h5a);
      wr(12'h610, 8'h26);
      wr(12'h600, 8'ha5);
      wr(12'h610, 8'h25);
      chk_rd(12'h600, 8'h5a);
      chk_rd(12'h610, 8'h25);
      wr(12'h610, 8'h26);
      chk_rd(12'h600, 8'ha5);
      $display("indirect test done");
   endtask : t_indirect
   // Holes, masked bits, ignored strobes and the converter words of both variants.
   task t_misc;
      wr(12'h614, 8'hff);
      chk_rd(12'h614, 8'h00);
      wr(12'h628, 8'hff);
      chk_rd(12'h628, 8'h1f);
      apb(12'h618, 1'b1, 8'h00, 4'h0);
      chk_rd(12'h618, 8'hff);
      wr(12'h688, 8'hff);
      chk_rd(12'h688, 8'hfd);
      `CHK(rd2, 32'h0)
      wr(12'h68c, 8'h55);
      chk_rd(12'h68c, 8'h55);
      `CHK(rd2, 32'h0)
      chk_rd(12'h684, 8'h3c);
      `CHK(rd2, 32'h0)
      chk_rd(12'h690, 8'h10);
      `CHK(rd2, 32'h3a)
      wr(12'h608, 8'h34);
      @(negedge clk);
      `CHK(pc, 13'h1f34)
      $display("misc test done");
   endtask : t_misc
   // Sleep, timeout and clear strobes, then a reset that is not power-on keeps the cause.
   task t_cause;
      wr(12'h680, 8'h04);
      @(negedge clk);
      `CHK(status[4:3], 2'b10)
      wr(12'h680, 8'h08);
      @(negedge clk);
      `CHK(status[4:3], 2'b00)
      wr(12'h680, 8'h10);
      @(negedge clk);
      `CHK(status[4:3], 2'b11)
      wr(12'h680, 8'h04);
      wr(12'h604, 8'h00);
      @(posedge clk);
      por <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK(status[4:3], 2'b10)
      `CHK(option, 8'hff)
      $display("cause test done");
   endtask : t_cause
   task wrap_up;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_status;
      t_indirect;
      t_misc;
      t_cause;
      wrap_up;
   end
   // Cuts a hang short well after the tests should have ended.
   initial begin
      repeat (3000) @(posedge clk);
      failures++;
      wrap_up;
   end
endmodule : test_special_register_bank_three_status
